// ==== core/ioicr_regs.svh ====
// register offsets, field positions and timing constants of the i/o interrupt control block
`ifndef IOICR_REGS_SVH
`define IOICR_REGS_SVH
`define IOICR_ADDR_CTRL      12'h000
`define IOICR_ADDR_STATUS    12'h004
`define IOICR_ADDR_MASK      12'h008
`define IOICR_ADDR_IRQ       12'h00C
`define IOICR_CTRL_ISE       0
`define IOICR_CTRL_STF_ISE   1
`define IOICR_STAT_PRESET_END 0
`define IOICR_STAT_CRS       1
`define IOICR_STAT_IAK       2
`define IOICR_EVT_W          3
`define IOICR_SC_CTRL        6'h00
`define IOICR_T0             3'h0
`define IOICR_T1             3'h1
`define IOICR_T2             3'h2
`define IOICR_T3             3'h3
`define IOICR_T5             3'h5
`define IOICR_T7             3'h7
`define IOICR_POWER_MS       100
`define IOICR_CLK_KHZ        50000
`define IOICR_POWER_CYCLES   (`IOICR_POWER_MS * `IOICR_CLK_KHZ)
`endif

// ==== core/ioicr_pkg.sv ====
// types shared by the i/o interrupt control block
package ioicr_pkg;
	typedef enum logic [1:0] {
		IOICR_PH_FETCH = 2'b00,
		IOICR_PH_OTHER = 2'b01,
		IOICR_PH_INT   = 2'b10,
		IOICR_PH_DMA   = 2'b11
	} ioicr_phase_t;
	typedef enum logic [1:0] {
		IOICR_PWR_HOLD = 2'b00,
		IOICR_PWR_WAIT = 2'b01,
		IOICR_PWR_RUN  = 2'b10
	} ioicr_pwr_t;
endpackage

// ==== core/ioicr_evt_if.sv ====
// event bundle from the core logic to the register slave, with the enable write strobes going back
`timescale 1ns/10ps
`default_nettype none
interface ioicr_evt_if;
	logic [2:0] evt;
	logic       ise;
	logic       icf;
	logic       preset;
	logic       ise_clr;
	logic       ise_set;
	modport core (output evt, output ise, output icf, output preset, input ise_clr, input ise_set);
	modport regs (input evt, input ise, input icf, input preset, output ise_clr, output ise_set);
endinterface
`default_nettype wire

// ==== core/ioicr_apb.sv ====
// apb register slave: control, sticky status, mask and interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "ioicr_regs.svh"
module ioicr_apb import ioicr_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	ioicr_evt_if.regs        ev
);
	logic [2:0]  status, next_status, mask, next_mask;
	logic [31:0] next_prdata;
	logic        next_irq, next_slverr, next_pready, acc, done, wr_ctrl;

	// one wait state: the first access cycle fetches, the second completes,
	// so read data, ready and error all come straight from flip-flops
	assign acc = psel & penable & ~pready;
	assign done = psel & penable & pready;
	assign wr_ctrl = done & pwrite & (paddr == `IOICR_ADDR_CTRL);
	assign ev.ise_set = wr_ctrl & pwdata[`IOICR_CTRL_STF_ISE];
	assign ev.ise_clr = wr_ctrl & ~pwdata[`IOICR_CTRL_STF_ISE];

	// sticky status: a new event wins over the read clear
	always_comb begin
		next_status = status;
		next_mask = mask;
		next_prdata = prdata;
		next_slverr = 1'b0;
		next_pready = acc;
		if (acc) begin
			if (~pwrite) begin
				unique case (paddr)
					`IOICR_ADDR_CTRL:   next_prdata = {30'h0, ev.icf, ev.ise};
					`IOICR_ADDR_STATUS: next_prdata = {29'h0, status};
					`IOICR_ADDR_MASK:   next_prdata = {29'h0, mask};
					`IOICR_ADDR_IRQ:    next_prdata = {31'h0, ev.preset};
					default: begin
						next_prdata = 32'h0;
						next_slverr = 1'b1;
					end
				endcase
			end else if ((paddr != `IOICR_ADDR_MASK) && (paddr != `IOICR_ADDR_CTRL)) begin
				next_slverr = 1'b1;
			end
		end else if (done & pwrite & (paddr == `IOICR_ADDR_MASK)) begin
			next_mask = pwdata[2:0];
		end else if (done & ~pwrite & (paddr == `IOICR_ADDR_STATUS)) begin
			// only the bits handed out are dropped; later events survive
			next_status = status & ~prdata[2:0];
		end
		next_status = next_status | ev.evt;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status <= 3'h0;
			mask <= 3'h0;
			prdata <= 32'h0;
			irq <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			status <= next_status;
			mask <= next_mask;
			prdata <= next_prdata;
			irq <= next_irq;
			pready <= next_pready;
			pslverr <= next_slverr;
		end
	end
endmodule // ioicr_apb
`default_nettype wire

// ==== core/ioicr_pwr.sv ====
// power-on timer: holds the preset request for its full length after power-up
`timescale 1ns/10ps
`default_nettype none
`include "ioicr_regs.svh"
module ioicr_pwr import ioicr_pkg::*; #(
	parameter int unsigned POWER_CYCLES = `IOICR_POWER_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      hold
);
	ioicr_pwr_t  state, next_state;
	logic [31:0] cnt, next_cnt;

	// count down the power-on interval, then stay in run
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		hold = (state != IOICR_PWR_RUN);
		unique case (state)
			IOICR_PWR_HOLD: begin
				next_cnt = POWER_CYCLES - 32'h1;
				next_state = IOICR_PWR_WAIT;
			end
			IOICR_PWR_WAIT: begin
				if (cnt == 32'h0)
					next_state = IOICR_PWR_RUN;
				else
					next_cnt = cnt - 32'h1;
			end
			IOICR_PWR_RUN: ;
			default: next_state = IOICR_PWR_HOLD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= IOICR_PWR_HOLD;
			cnt <= 32'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end
endmodule // ioicr_pwr
`default_nettype wire

// ==== core/ioicr_top.sv ====
// i/o interrupt control and reset distribution core
// Overview of operation
// - after power-up hold the preset pulse asserted for 100 ms
// - processor starts halted in fetch and is still in fetch when preset ends
// - the preset pulse begins at T5 of the fetch phase
// - with power on, preset follows the front-panel preset input while held
// - preset clears the interrupt system enable flip-flop
// - service request enable is false while system enable is clear
// - buffered preset goes to all slots; cards set flag buffers from it
// - flag enable strobe at T2; cards clear request, set flag from buffer
// - preset makes control reset strobe, clearing card control and interrupt control
// - clear control to select code 00 also makes control reset strobe
// - service request enable stays false until after T7 of first phase
// - with interrupt control clear, acknowledge strobe issues at T1 of fetch
// - set request strobe broadcast at every T5
// - set request strobe sets the second phase sync flip-flop
// - T7 sets timing flip-flop; its fall at T0 sets interrupt control
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ioicr_regs.svh"
module ioicr_top import ioicr_pkg::*; #(
	parameter int unsigned POWER_CYCLES = `IOICR_POWER_CYCLES
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [2:0]   time_state,
	input  wire ioicr_phase_t phase,
	input  wire logic         front_preset,
	input  wire logic         clear_control_instruction,
	input  wire logic         io_group,
	input  wire logic [5:0]   select_code,
	input  wire logic         set_flag_instruction,
	input  wire logic         clear_flag_instruction,
	input  wire logic         set_control_instruction,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	output logic              irq,
	output logic              power_on_preset_pulse,
	output logic              buffered_preset_pulse,
	output logic              halt_request,
	output logic              service_request_enable,
	output logic              control_reset_strobe,
	output logic              flag_enable_strobe,
	output logic              set_request_strobe,
	output logic              interrupt_ack_strobe,
	output logic              second_phase_sync_ff
);
	ioicr_evt_if ev ();

	logic power_hold;
	logic ise, next_ise;
	logic icf, next_icf;
	logic itf, next_itf;
	logic preset_arm, next_preset_arm;
	logic next_preset, next_bpreset, next_halt, next_esr;
	logic next_crs, next_enf, next_sir, next_iak, next_sync2;
	logic prio_instr, sc_clear;
	logic preset_src, pwr_rst;

	////////////////////////////////////////////////////////////////
	// helpers and submodules

	// one time-state decode used for every strobe
	function automatic logic at_ts(input logic [2:0] ts, input logic [2:0] want);
		return ts == want;
	endfunction

	ioicr_pwr #(
		.POWER_CYCLES (POWER_CYCLES)
	) u_pwr (
		.clk  (clk),
		.rst  (pwr_rst),
		.hold (power_hold)
	);

	ioicr_apb u_apb (
		.clk     (clk),
		.rst     (rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.irq     (irq),
		.ev      (ev)
	);

	////////////////////////////////////////////////////////////////
	// preset pulse and interrupt flip-flops

	// instruction decodes; prioritising instructions also drop interrupt control
	assign sc_clear = clear_control_instruction & io_group & (select_code == `IOICR_SC_CTRL);
	assign prio_instr = io_group & (clear_control_instruction | set_control_instruction |
		set_flag_instruction | clear_flag_instruction) & (phase != IOICR_PH_DMA);

	// the power timer waits for the pulse to start, so the pulse gets its full length
	assign pwr_rst = rst | ~preset_arm;
	assign preset_src = power_hold | front_preset;

	always_comb begin
		// power-up pulse starts at T5 of fetch; a panel press starts it at once
		next_preset = power_on_preset_pulse ? preset_src :
			((power_hold & at_ts(time_state, `IOICR_T5) & (phase == IOICR_PH_FETCH)) | front_preset);
		next_preset_arm = preset_arm | next_preset;
		next_bpreset = next_preset;
		// halted in fetch for the whole power-on interval
		next_halt = power_hold;
		next_crs = next_preset | sc_clear;

		next_ise = ise;
		if (next_preset)
			next_ise = 1'b0;
		else if (ev.ise_set)
			next_ise = 1'b1;
		else if (ev.ise_clr)
			next_ise = 1'b0;

		// timing flip-flop: set at T7, cleared at T0; its fall re-arms control
		next_itf = itf;
		if (at_ts(time_state, `IOICR_T7))
			next_itf = 1'b1;
		else if (at_ts(time_state, `IOICR_T0))
			next_itf = 1'b0;

		next_icf = icf;
		if (next_crs | prio_instr | ((phase == IOICR_PH_INT) & at_ts(time_state, `IOICR_T3)))
			next_icf = 1'b0;
		else if (itf & at_ts(time_state, `IOICR_T0) & ~power_on_preset_pulse)
			next_icf = 1'b1;

		next_esr = next_ise & next_icf;
		next_enf = at_ts(time_state, `IOICR_T2);
		next_sir = at_ts(time_state, `IOICR_T5);
		// cards ignore this while preset is high, which the cards keep themselves
		next_iak = ~icf & at_ts(time_state, `IOICR_T1) & (phase == IOICR_PH_FETCH);
		next_sync2 = second_phase_sync_ff | next_sir;
		if (next_preset | (phase == IOICR_PH_DMA))
			next_sync2 = 1'b0;
	end

	// all broadcast outputs are registered straight from flip-flops
	always_ff @(posedge clk) begin
		if (rst) begin
			ise <= 1'b0;
			icf <= 1'b0;
			itf <= 1'b0;
			preset_arm <= 1'b0;
			power_on_preset_pulse <= 1'b0;
			buffered_preset_pulse <= 1'b0;
			halt_request <= 1'b1;
			service_request_enable <= 1'b0;
			control_reset_strobe <= 1'b0;
			flag_enable_strobe <= 1'b0;
			set_request_strobe <= 1'b0;
			interrupt_ack_strobe <= 1'b0;
			second_phase_sync_ff <= 1'b0;
		end else begin
			ise <= next_ise;
			icf <= next_icf;
			itf <= next_itf;
			preset_arm <= next_preset_arm;
			power_on_preset_pulse <= next_preset;
			buffered_preset_pulse <= next_bpreset;
			halt_request <= next_halt;
			service_request_enable <= next_esr;
			control_reset_strobe <= next_crs;
			flag_enable_strobe <= next_enf;
			set_request_strobe <= next_sir;
			interrupt_ack_strobe <= next_iak;
			second_phase_sync_ff <= next_sync2;
		end
	end

	////////////////////////////////////////////////////////////////
	// events to the register block

	assign ev.ise = ise;
	assign ev.icf = icf;
	assign ev.preset = power_on_preset_pulse;
	assign ev.evt[`IOICR_STAT_PRESET_END] = power_on_preset_pulse & ~next_preset;
	assign ev.evt[`IOICR_STAT_CRS] = next_crs & ~control_reset_strobe;
	assign ev.evt[`IOICR_STAT_IAK] = next_iak;
endmodule // ioicr_top
`default_nettype wire

// ==== test/ioicr_properties.sv ====
// concurrent checks on the ports of the i/o interrupt control core
`timescale 1ns/10ps
`default_nettype none
module ioicr_chk import ioicr_pkg::*; #(
	parameter int unsigned POWER_CYCLES = 20
) (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic [2:0]   time_state,
	input wire ioicr_phase_t phase,
	input wire logic         front_preset,
	input wire logic         clear_control_instruction,
	input wire logic         io_group,
	input wire logic [5:0]   select_code,
	input wire logic         power_on_preset_pulse,
	input wire logic         buffered_preset_pulse,
	input wire logic         service_request_enable,
	input wire logic         control_reset_strobe,
	input wire logic         flag_enable_strobe,
	input wire logic         set_request_strobe,
	input wire logic         interrupt_ack_strobe,
	input wire logic         second_phase_sync_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// steps of a preset release and of a clear-control to code zero
	sequence s_release;
		$fell(power_on_preset_pulse);
	endsequence
	sequence s_clc_zero;
		clear_control_instruction && io_group && select_code == 6'h00;
	endsequence
	// the power-up pulse may only start on fetch T5; a panel press starts it anywhere
	a_start_on_t5: assert property ($rose(power_on_preset_pulse) && !$past(front_preset)
		|-> $past(time_state) == 3'h5 && $past(phase) == IOICR_PH_FETCH) else $error("preset start off T5");
	a_panel_holds: assert property (front_preset && $past(front_preset) |-> power_on_preset_pulse)
		else $error("preset not following panel");
	a_buffer_copy: assert property (buffered_preset_pulse == power_on_preset_pulse)
		else $error("buffered preset differs");
	a_esr_off_preset: assert property (power_on_preset_pulse && $past(power_on_preset_pulse, 2)
		|-> !service_request_enable) else $error("enable during preset");
	a_crs_preset: assert property (power_on_preset_pulse && $past(power_on_preset_pulse)
		|-> control_reset_strobe) else $error("no control reset in preset");
	a_crs_clc_zero: assert property (s_clc_zero |=> control_reset_strobe) else $error("no control reset on clc");
	a_enf_on_t2: assert property (time_state == 3'h2 |=> flag_enable_strobe) else $error("flag enable missed");
	a_sir_on_t5: assert property (time_state == 3'h5 |=> set_request_strobe) else $error("set request missed");
	a_sir_only_t5: assert property (set_request_strobe && !$past(rst) |-> $past(time_state) == 3'h5)
		else $error("stray set request");
	a_ack_fetch_t1: assert property (interrupt_ack_strobe |-> $past(time_state) == 3'h1
		&& $past(phase) == IOICR_PH_FETCH) else $error("ack off fetch T1");
	a_sync_sets: assert property (set_request_strobe && !power_on_preset_pulse && phase == IOICR_PH_FETCH
		|-> ##[0:1] second_phase_sync_ff) else $error("sync flop not set");
	a_quiet_release: assert property (s_release |-> !service_request_enable [*2])
		else $error("enable right after release");
endmodule // ioicr_chk
bind ioicr_top ioicr_chk #(.POWER_CYCLES(POWER_CYCLES)) u_chk (.clk, .rst, .time_state, .phase, .front_preset,
	.clear_control_instruction, .io_group, .select_code, .power_on_preset_pulse, .buffered_preset_pulse,
	.service_request_enable, .control_reset_strobe, .flag_enable_strobe, .set_request_strobe,
	.interrupt_ack_strobe, .second_phase_sync_ff);
`default_nettype wire

// ==== test/ioicr_cpu_model.sv ====
// processor timing model: time states and machine phase
`timescale 1ns/10ps
`default_nettype none
module ioicr_cpu_model import ioicr_pkg::*; (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          halt_request,
	input  wire ioicr_phase_t  next_phase_req,
	output logic [2:0]         time_state,
	output ioicr_phase_t       phase
);
	logic [2:0]   next_time_state;
	ioicr_phase_t next_phase;
	// one time state a clock; a new phase begins after T7, except that a halt forces fetch at once
	always_comb begin
		next_time_state = time_state + 3'h1;
		next_phase      = phase;
		if (halt_request) begin
			next_phase = IOICR_PH_FETCH; // halted machine sits in fetch
		end else if (time_state == 3'h7) begin
			next_phase = next_phase_req;
		end
	end
	// state registers
	always_ff @(posedge clk) begin
		if (rst) begin
			time_state <= 3'h0;
			phase      <= IOICR_PH_FETCH;
		end else begin
			time_state <= next_time_state;
			phase      <= next_phase;
		end
	end
endmodule // ioicr_cpu_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the i/o interrupt control core
`timescale 1ns/10ps
`default_nettype none
`include "ioicr_regs.svh"
module tb import ioicr_pkg::*; ;
	localparam int unsigned PC = 20;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         front_preset = 1'b0;
	logic         clear_control_instruction = 1'b0;
	logic         io_group = 1'b0;
	logic [5:0]   select_code = 6'h00;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata, rd;
	logic [2:0]   time_state;
	ioicr_phase_t phase;
	logic         pready, pslverr, irq, power_on_preset_pulse, buffered_preset_pulse, halt_request, er;
	logic         service_request_enable, control_reset_strobe, flag_enable_strobe;
	logic         set_request_strobe, interrupt_ack_strobe, second_phase_sync_ff;
	int           fails = 0;
	int           checks = 0;
	int           n;
	logic         card_buf = 1'b0;
	logic         card_flag = 1'b0;
	logic         card_ctl = 1'b0;
	logic         card_req = 1'b0;
	// one interface card on the far side
	always @(posedge clk) begin
		if (buffered_preset_pulse)
			card_buf <= 1'b1;
		else if (interrupt_ack_strobe && card_req)
			card_buf <= 1'b0;
		if (flag_enable_strobe && card_buf)
			card_flag <= 1'b1;
		if (control_reset_strobe)
			card_ctl <= 1'b0;
		if (flag_enable_strobe)
			card_req <= 1'b0;
		else if (set_request_strobe && card_flag && card_ctl)
			card_req <= 1'b1;
	end
	ioicr_top #(.POWER_CYCLES(PC)) u_dut (.clk, .rst, .time_state, .phase, .front_preset, .clear_control_instruction,
		.io_group, .select_code, .set_flag_instruction(1'b0), .clear_flag_instruction(1'b0),
		.set_control_instruction(1'b0), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
		.power_on_preset_pulse, .buffered_preset_pulse, .halt_request, .service_request_enable,
		.control_reset_strobe, .flag_enable_strobe, .set_request_strobe, .interrupt_ack_strobe, .second_phase_sync_ff);
	ioicr_cpu_model u_cpu (.clk, .rst, .halt_request, .next_phase_req(IOICR_PH_FETCH), .time_state, .phase);
	////////////////////////////////////////
	// 50 MHz clock
	always #10 clk = ~clk;
	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request stands until pready is seen; data and error are taken at that edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			fails++;
			report_and_stop();
		end
		er = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return power_on_preset_pulse;
			1: return service_request_enable;
			default: return irq;
		endcase
	endfunction
	// bounded wait, n keeps the cycles spent; a hang ends the run
	task automatic wait_on(input int s, input logic v, input int lim);
		n = 0;
		while (sig(s) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			fails++;
			report_and_stop();
		end
	endtask
	////////////////////////////////////////
	// power-up, registers, clear control, panel preset
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk({halt_request, service_request_enable, irq}, 3'h4);
		wait_on(0, 1'b1, 100);
		chk({halt_request, phase}, {1'b1, IOICR_PH_FETCH});
		wait_on(0, 1'b0, 40);
		chk(n >= PC && n <= PC + 4, 1'b1);
		chk({phase, service_request_enable}, {IOICR_PH_FETCH, 1'b0});
		apb(1'b1, `IOICR_ADDR_CTRL, 32'h2);
		wait_on(1, 1'b1, 20);
		apb(1'b0, `IOICR_ADDR_CTRL, 32'h0);
		chk(rd[1:0], 2'h3);
		apb(1'b0, `IOICR_ADDR_STATUS, 32'h0);
		chk(rd[2:0], 3'h7);
		apb(1'b0, `IOICR_ADDR_STATUS, 32'h0);
		chk(rd[2:0], 3'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, `IOICR_ADDR_STATUS, 32'h5);
		chk(er, 1'b1);
		apb(1'b0, `IOICR_ADDR_IRQ, 32'h0);
		chk({er, rd[0]}, 2'h0);
		apb(1'b1, `IOICR_ADDR_MASK, 32'h2);
		// code one must not reset card control, code zero must
		for (int i = 1; i >= 0; i--) begin
			clear_control_instruction <= 1'b1;
			io_group <= 1'b1;
			select_code <= 6'(i);
			@(posedge clk);
			clear_control_instruction <= 1'b0;
			io_group <= 1'b0;
			@(posedge clk);
			chk(control_reset_strobe, i == 0);
		end
		wait_on(1, 1'b0, 4);
		wait_on(1, 1'b1, 12);
		wait_on(2, 1'b1, 4);
		apb(1'b0, `IOICR_ADDR_STATUS, 32'h0);
		chk(rd[1], 1'b1);
		wait_on(2, 1'b0, 4);
		front_preset <= 1'b1;
		wait_on(0, 1'b1, 4);
		repeat (10) @(posedge clk);
		chk({power_on_preset_pulse, service_request_enable}, 2'h2);
		chk({card_buf, card_flag, card_req}, 3'h6);
		front_preset <= 1'b0;
		wait_on(0, 1'b0, 4);
		apb(1'b0, `IOICR_ADDR_CTRL, 32'h0);
		chk(rd[0], 1'b0);
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
